// file: verilog/atx_pkg.sv
// Shared constants and types of the asynchronous transmit block
`default_nettype none
package atx_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] ADDR_PORT_FN = 16'hFF91;
    localparam logic [15:0] ADDR_GP = 16'hFF92;
    localparam logic [15:0] ADDR_MODE = 16'hFF98;
    localparam logic [15:0] ADDR_BAUD = 16'hFF99;
    localparam logic [15:0] ADDR_CTRL = 16'hFF9A;
    localparam logic [15:0] ADDR_HOLD = 16'hFF9B;
    localparam logic [15:0] ADDR_STAT = 16'hFF9C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PF_TXD_SEL = 4;
    localparam int PF_ALT_SEL = 5;
    localparam int GP_OUT = 0;
    localparam int GP_DIR = 1;
    localparam int GP_PIN = 7;
    localparam int MODE_STOP2 = 3;
    localparam int MODE_CHR7 = 6;
    localparam int CTRL_TE = 5;
    localparam int ST_TX_HOLDING_EMPTY = 7;
    localparam int ST_TX_COMPLETE_FLAG = 2;

    // ************************************************************
    // Reset values and frame counts
    // ************************************************************
    localparam logic [7:0] PORT_FN_RST = 8'h00;
    localparam logic [7:0] GP_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h0F;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] HOLD_RST = 8'hFF;
    localparam logic [3:0] DATA8_LAST = 4'h7;
    localparam logic [3:0] DATA7_LAST = 4'h6;

    typedef enum logic [1:0] {SH_IDLE, SH_START, SH_DATA, SH_STOP} atx_sh_state_t;

endpackage : atx_pkg
`default_nettype wire

// file: verilog/atx_stream_if.sv
// Valid/ready byte stream between the transmit stages
`timescale 1ns/1ps
`default_nettype none
interface atx_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : atx_stream_if
`default_nettype wire

// file: verilog/atx_buf2.sv
// Small valid/ready buffer ahead of the shift stage
`timescale 1ns/1ps
`default_nettype none
module atx_buf2 import atx_pkg::*; #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic flush_i,
    atx_stream_if.snk in_s,
    atx_stream_if.src out_s
);
    // DEPTH must be a power of two so the pointers wrap by themselves
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] next_mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic push, pop;

    assign in_s.ready = (count != (PW+1)'(DEPTH)) && !flush_i;
    assign out_s.valid = (count != '0) && !flush_i;
    assign out_s.data = mem[rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (flush_i) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end else begin
            if (push) begin
                next_mem[wr_ptr] = in_s.data;
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (pop) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
            next_count = count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

endmodule : atx_buf2
`default_nettype wire

// file: verilog/atx_shifter.sv
// Serial framer: start bit, data bits LSB first, stop bits
`timescale 1ns/1ps
`default_nettype none
module atx_shifter import atx_pkg::*; (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic chr7_i,
    input wire logic stop2_i,
    input wire logic [7:0] bit_len_i,
    atx_stream_if.snk in_s,
    output logic txd_o,
    output logic done_o
);
    atx_sh_state_t st, next_st;
    logic [7:0] shreg, next_shreg;
    logic [7:0] tick, next_tick;
    logic [3:0] bcnt, next_bcnt;
    logic next_txd;
    logic bit_end;
    logic [3:0] last_idx;

    assign bit_end = (tick == bit_len_i);
    assign last_idx = chr7_i ? DATA7_LAST : DATA8_LAST;
    assign done_o = en_i && (st == SH_STOP) && bit_end && (!stop2_i || bcnt != 4'h0);
    // Take the next byte on the last stop tick so frames run back to back
    assign in_s.ready = en_i && (st == SH_IDLE || done_o);

    always_comb begin
        next_st = st;
        next_shreg = shreg;
        next_bcnt = bcnt;
        next_txd = txd_o;
        next_tick = bit_end ? 8'h00 : tick + 8'h01;
        if (!en_i) begin
            next_st = SH_IDLE;
            next_txd = 1'b1;
            next_tick = 8'h00;
        end else if (in_s.valid && in_s.ready) begin
            next_st = SH_START;
            next_shreg = in_s.data;
            next_txd = 1'b0;
            next_tick = 8'h00;
        end else begin
            case (st)
                SH_IDLE: begin
                    next_txd = 1'b1;
                    next_tick = 8'h00;
                end
                SH_START: begin
                    if (bit_end) begin
                        next_st = SH_DATA;
                        next_bcnt = 4'h0;
                        next_txd = shreg[0];
                    end
                end
                SH_DATA: begin
                    if (bit_end && bcnt == last_idx) begin
                        next_st = SH_STOP;
                        next_bcnt = 4'h0;
                        next_txd = 1'b1;
                    end else if (bit_end) begin
                        next_shreg = {1'b1, shreg[7:1]};
                        next_bcnt = bcnt + 4'h1;
                        next_txd = shreg[1];
                    end
                end
                SH_STOP: begin
                    if (done_o) begin
                        next_st = SH_IDLE;
                    end else if (bit_end) begin
                        next_bcnt = 4'h1;
                    end
                end
                default: begin
                    next_st = SH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= SH_IDLE;
            shreg <= 8'hFF;
            tick <= 8'h00;
            bcnt <= 4'h0;
            txd_o <= 1'b1;
        end else begin
            st <= next_st;
            shreg <= next_shreg;
            tick <= next_tick;
            bcnt <= next_bcnt;
            txd_o <= next_txd;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_start_low: assert property ((st == SH_START) |-> !txd_o)
        else $error("start bit not low");
    a_stop_high: assert property ((st == SH_STOP || st == SH_IDLE) |-> txd_o)
        else $error("line not high in stop or idle");

endmodule : atx_shifter
`default_nettype wire

// file: verilog/atx_top.sv
// Transmit side of an asynchronous serial channel with pin routing
//
// Summary of operation
// - Pin-select bit 4 routes the shared pin: 0 general port, 1 serial out.
// - Serial transmission only runs while transmit enable bit 5 is 1.
// - Holding-empty flag reads 1 while transmit enable is 0.
// - Byte write with enable 1 clears holding-empty and starts sending.
// - Transmit-end flag, status bit 2, is set while enable is 0.
// - Transmit-end sets when the last bit leaves with nothing waiting.
// - Writing 0 to holding-empty after reading 1 clears transmit-end.
// - Writing a holding byte also clears transmit-end.
// - Pending byte moves to the shifter as soon as it frees up.
// - Holding-empty sets when a byte leaves the holding register, unless a holding write lands in the same cycle.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module atx_top import atx_pkg::*; (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic alt_pin_o,
    output logic alt_pin_oe_o
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] port_fn, next_port_fn;
    logic [7:0] gp, next_gp;
    logic [7:0] mode, next_mode;
    logic [7:0] baud, next_baud;
    logic [7:0] ctrl, next_ctrl;
    logic [7:0] hold_data, next_hold_data;
    logic hold_full, next_hold_full;
    logic tx_holding_empty, next_tx_holding_empty;
    logic tx_complete_flag, next_tx_complete_flag;
    // Set by a status read that saw holding-empty as one
    logic tx_holding_empty_seen, next_tx_holding_empty_seen;
    logic [7:0] next_rdata;
    logic pin_s1, pin_s2, pin_s3;
    logic pin_level, next_pin_level;
    logic te, txd_sel, alt_sel, txd_line, done;
    logic tx_holding_empty_view, tx_complete_flag_view;
    logic hold_wr, stat_wr, stat_rd, clr_ok, xfer;

    atx_stream_if #(.W(8)) hs ();
    atx_stream_if #(.W(8)) bs ();

    assign te = ctrl[CTRL_TE];
    assign txd_sel = port_fn[PF_TXD_SEL];
    assign alt_sel = port_fn[PF_ALT_SEL];
    assign hold_wr = wr_i && (addr_i == ADDR_HOLD);
    assign stat_wr = wr_i && (addr_i == ADDR_STAT);
    assign stat_rd = rd_i && (addr_i == ADDR_STAT);
    // Only a zero written after a read of one counts as a clear
    assign clr_ok = stat_wr && !wdata_i[ST_TX_HOLDING_EMPTY] && tx_holding_empty_seen;

    assign tx_holding_empty_view = tx_holding_empty || !te;
    assign tx_complete_flag_view = tx_complete_flag || !te;

    // ************************************************************
    // Data path: holding register, buffer, shifter
    // ************************************************************
    // hand-over gated by enable
    assign hs.valid = hold_full && te;
    assign hs.data = hold_data;
    assign xfer = hs.valid && hs.ready;

    atx_buf2 #(.W(8), .DEPTH(2)) u_buf (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .flush_i(!te),
        .in_s(hs.snk),
        .out_s(bs.src)
    );

    // shifter pulls the next byte without a gap
    atx_shifter u_shift (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .en_i(te),
        .chr7_i(mode[MODE_CHR7]),
        .stop2_i(mode[MODE_STOP2]),
        .bit_len_i(baud),
        .in_s(bs.snk),
        .txd_o(txd_line),
        .done_o(done)
    );

    // ************************************************************
    // Pin routing
    // ************************************************************
    // pin select picks serial or port
    assign pin_o = txd_sel ? txd_line : gp[GP_OUT];
    assign pin_oe_o = txd_sel || gp[GP_DIR];
    // Unselected second pin idles high, so no false start leaves it
    assign alt_pin_o = alt_sel ? txd_line : 1'b1;
    assign alt_pin_oe_o = alt_sel;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_comb begin
        next_port_fn = port_fn;
        next_gp = gp;
        next_mode = mode;
        next_baud = baud;
        next_ctrl = ctrl;
        next_hold_data = hold_data;
        if (wr_i) begin
            case (addr_i)
                ADDR_PORT_FN: next_port_fn = wdata_i;
                ADDR_GP: next_gp = wdata_i;
                ADDR_MODE: next_mode = wdata_i;
                ADDR_BAUD: next_baud = wdata_i;
                ADDR_CTRL: next_ctrl = wdata_i;
                ADDR_HOLD: next_hold_data = wdata_i;
                default: next_ctrl = ctrl;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_fn <= PORT_FN_RST;
            gp <= GP_RST;
            mode <= MODE_RST;
            baud <= BAUD_RST;
            ctrl <= CTRL_RST;
            hold_data <= HOLD_RST;
        end else begin
            port_fn <= next_port_fn;
            gp <= next_gp;
            mode <= next_mode;
            baud <= next_baud;
            ctrl <= next_ctrl;
            hold_data <= next_hold_data;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    always_comb begin
        next_hold_full = hold_full;
        next_tx_holding_empty = tx_holding_empty;
        next_tx_complete_flag = tx_complete_flag;
        next_tx_holding_empty_seen = tx_holding_empty_seen;
        if (!te) begin
            next_hold_full = 1'b0;
        end else if (hold_wr) begin
            next_hold_full = 1'b1;
        end else if (xfer) begin
            next_hold_full = 1'b0;
        end
        // transfer sets unless a holding write lands, and beats a status clear
        if (!te || (xfer && !hold_wr)) begin
            next_tx_holding_empty = 1'b1;
        end else if (hold_wr || clr_ok) begin
            next_tx_holding_empty = 1'b0;
        end
        if (!te || (done && tx_holding_empty && !bs.valid)) begin
            next_tx_complete_flag = 1'b1;
        end else if (clr_ok || hold_wr) begin
            next_tx_complete_flag = 1'b0;
        end
        // Any status write spends the read, so a stale read cannot clear
        if (stat_rd && tx_holding_empty_view) begin
            next_tx_holding_empty_seen = 1'b1;
        end else if (stat_wr) begin
            next_tx_holding_empty_seen = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_full <= 1'b0;
            tx_holding_empty <= 1'b1;
            tx_complete_flag <= 1'b1;
            tx_holding_empty_seen <= 1'b0;
        end else begin
            hold_full <= next_hold_full;
            tx_holding_empty <= next_tx_holding_empty;
            tx_complete_flag <= next_tx_complete_flag;
            tx_holding_empty_seen <= next_tx_holding_empty_seen;
        end
    end

    // ************************************************************
    // Port pin input and read port
    // ************************************************************
    // Two agreeing samples filter a slow or bouncing edge
    assign next_pin_level = (pin_s2 == pin_s3) ? pin_s2 : pin_level;

    always_comb begin
        next_rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ADDR_PORT_FN: next_rdata = port_fn;
                ADDR_GP: next_rdata = {pin_level, gp[6:0]};
                ADDR_MODE: next_rdata = mode;
                ADDR_BAUD: next_rdata = baud;
                ADDR_CTRL: next_rdata = ctrl;
                ADDR_HOLD: next_rdata = hold_data;
                ADDR_STAT: begin
                    next_rdata[ST_TX_HOLDING_EMPTY] = tx_holding_empty_view;
                    next_rdata[ST_TX_COMPLETE_FLAG] = tx_complete_flag_view;
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
            pin_level <= 1'b1;
            rdata_o <= 8'h00;
        end else begin
            pin_s1 <= pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= next_pin_level;
            rdata_o <= next_rdata;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_read_one;
        stat_rd && tx_holding_empty_view;
    endsequence
    sequence s_write_zero;
        stat_wr && !wdata_i[ST_TX_HOLDING_EMPTY] && te && !done && !$past(!te);
    endsequence
    sequence s_idle_write;
        hold_wr && te && !hold_full && !bs.valid && bs.ready ##1 te ##1 te;
    endsequence

    a_pin_port_mode: assert property (!txd_sel |-> pin_o == gp[GP_OUT])
        else $error("port pin not driven by port data");
    a_pin_idle_high: assert property (txd_sel && !te && $past(!te) |-> pin_o && pin_oe_o)
        else $error("serial pin not idling high");
    a_no_tx_off: assert property (!te && $past(!te) |-> txd_line)
        else $error("line active while transmit disabled");
    a_tx_holding_empty_off_read: assert property (stat_rd && !te |=> rdata_o[ST_TX_HOLDING_EMPTY])
        else $error("holding-empty not read as one");
    a_write_clears: assert property (hold_wr && te |=> !tx_holding_empty && hold_full)
        else $error("holding write did not clear holding-empty");
    a_tx_complete_flag_off_read: assert property (stat_rd && !te |=> rdata_o[ST_TX_COMPLETE_FLAG])
        else $error("transmit-end not read as one");
    a_tx_complete_flag_sets: assert property (done && tx_holding_empty && !bs.valid && te |=> tx_complete_flag)
        else $error("transmit-end missed at frame end");
    a_tx_complete_flag_clr_seq: assert property (s_read_one ##1 s_write_zero |=> !tx_complete_flag && !tx_holding_empty)
        else $error("read then zero write did not clear");
    a_tx_complete_flag_clr_wr: assert property (hold_wr && te && !done && $past(te) |=> !tx_complete_flag)
        else $error("holding write did not clear transmit-end");
    a_tx_complete_flag_ro: assert property (stat_wr && wdata_i[ST_TX_COMPLETE_FLAG] && !tx_complete_flag && te
            && !done |=> !tx_complete_flag)
        else $error("transmit-end changed by a write");
    a_frame_no_gap: assert property (done && bs.valid && te ##1 te |-> !txd_line)
        else $error("next frame not started at once");
    a_xfer_sets: assert property (xfer && !hold_wr |=> tx_holding_empty)
        else $error("holding-empty not set on transfer");

    // An idle channel shows its start bit three edges after the write
    a_write_starts: assert property (s_idle_write |=> !txd_line)
        else $error("holding write did not start a frame");
    a_pin_serial: assert property (txd_sel |-> pin_oe_o && pin_o == txd_line)
        else $error("serial pin not routed");
    a_alt_pin_route: assert property (alt_sel |-> alt_pin_oe_o && alt_pin_o == txd_line)
        else $error("second serial pin not routed");
    // Disable drops the waiting byte as well
    a_flags_off: assert property (!te |=> tx_holding_empty && tx_complete_flag && !hold_full)
        else $error("flags not forced while disabled");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not cleared");
    a_status_spare: assert property (stat_rd |=> (rdata_o & 8'h7B) == 8'h00)
        else $error("unused status bits not zero");
    // Only a level seen twice in a row may reach the port read
    a_pin_filter: assert property ($changed(pin_level) |-> $past(pin_s2) == $past(pin_s3))
        else $error("pin level took an unconfirmed sample");

endmodule : atx_top
`default_nettype wire

// file: testbench/atx_rx_model.sv
// Behavioural remote receiver watching the serial line
`timescale 1ns/1ps
`default_nettype none
module atx_rx_model #(
    parameter int BIT = 4
) (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic chr7_i,
    input wire logic stop2_i
);
    logic [7:0] got[$];
    int starts[$];
    int frame_err = 0;
    int cyc = 0;
    logic [7:0] d;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    // ************************************************************
    // Frame decoder
    // ************************************************************
    // start low, data LSB first, stop high
    initial begin
        forever begin
            @(posedge clk_i);
            if (line_i === 1'b0) begin
                starts.push_back(cyc);
                d = 8'h00;
                // Mid-bit sampling tolerates the edge phase
                repeat (BIT / 2) @(posedge clk_i);
                if (line_i !== 1'b0) frame_err++;
                for (int i = 0; i < (chr7_i ? 7 : 8); i++) begin
                    repeat (BIT) @(posedge clk_i);
                    d[i] = line_i;
                end
                for (int i = 0; i < (stop2_i ? 2 : 1); i++) begin
                    repeat (BIT) @(posedge clk_i);
                    if (line_i !== 1'b1) frame_err++;
                end
                got.push_back(d);
            end
        end
    end
endmodule : atx_rx_model
`default_nettype wire

// file: testbench/async_serial_tx_enable_end_tb.sv
// Self-checking bench of the transmit block
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_enable_end_tb;
    import atx_pkg::*;
    localparam int BIT = 4;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic pin_i = 1'b1;
    logic [7:0] rdata_o;
    logic pin_o, pin_oe_o, alt_pin_o, alt_pin_oe_o;
    logic chr7 = 1'b0;
    logic stop2 = 1'b0;
    logic te = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] r;
    int err_total = 0;
    int num_checks = 0;
    int lows;
    // Pull-up holds the released pin high
    wire line = pin_oe_o ? pin_o : 1'b1;

    always #5 clk_i = ~clk_i;

    atx_top atx_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .alt_pin_o(alt_pin_o), .alt_pin_oe_o(alt_pin_oe_o));
    atx_rx_model #(.BIT(BIT)) atx_rx_model_i (.clk_i(clk_i), .line_i(line), .chr7_i(chr7),
        .stop2_i(stop2));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Bus write; the model tracks enable, mode and queued bytes
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (a == ADDR_CTRL) te = d[CTRL_TE];
        if (a == ADDR_MODE) begin
            chr7 = d[MODE_CHR7];
            stop2 = d[MODE_STOP2];
        end
        if (a == ADDR_HOLD && te) exp_q.push_back(chr7 ? {1'b0, d[6:0]} : d);
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    task automatic chk_st(input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] s;
        rd(ADDR_STAT, s);
        chk(s & mask, exp, "status");
    endtask : chk_st

    task automatic chk_pins(input logic [7:0] exp);
        repeat (2) @(posedge clk_i);
        #1;
        chk({4'h0, pin_oe_o, pin_o, alt_pin_oe_o, alt_pin_o}, exp, "pins");
    endtask : chk_pins

    // Waits for all queued bytes, then lets the last stop bit end
    task automatic drain();
        for (int n = 0; n < 5000 && atx_rx_model_i.got.size() < exp_q.size(); n++)
            @(posedge clk_i);
        repeat (3 * BIT) @(posedge clk_i);
        chk(8'(atx_rx_model_i.got.size()), 8'(exp_q.size()), "frame count");
        foreach (exp_q[i]) chk(atx_rx_model_i.got[i], exp_q[i], "rx byte");
        atx_rx_model_i.got.delete();
        exp_q.delete();
    endtask : drain

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        void'($urandom(40));
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(ADDR_PORT_FN, r);
        chk(r, PORT_FN_RST, "port fn reset");
        rd(ADDR_CTRL, r);
        chk(r, CTRL_RST, "ctrl reset");
        rd(ADDR_BAUD, r);
        chk(r, BAUD_RST, "baud reset");
        chk_st(8'h84, 8'h84);
        rd(16'hFF90, r);
        chk(r, 8'h00, "unmapped read");
        $display("test reset done");

        wr(ADDR_GP, 8'h03);
        chk_pins(8'h0D);
        wr(ADDR_GP, 8'h02);
        chk_pins(8'h09);
        @(posedge clk_i);
        pin_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(ADDR_GP, r);
        chk(r, 8'h02, "port pin low");
        @(posedge clk_i);
        pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(ADDR_GP, r);
        chk(r, 8'h82, "port pin high");
        wr(ADDR_PORT_FN, 8'h30);
        chk_pins(8'h0F);
        wr(ADDR_PORT_FN, 8'h10);
        chk_pins(8'h0D);
        // Port-driven low looked like a start bit to the receiver
        repeat (12 * BIT) @(posedge clk_i);
        atx_rx_model_i.starts.delete();
        atx_rx_model_i.got.delete();
        $display("test pin routing done");

        wr(ADDR_MODE, 8'h00);
        wr(ADDR_BAUD, 8'(BIT - 1));
        wr(ADDR_HOLD, 8'($urandom));
        repeat (12 * BIT) @(posedge clk_i);
        chk(8'(atx_rx_model_i.starts.size()), 8'h00, "no frame while disabled");
        chk_st(8'h84, 8'h84);
        $display("test disabled done");

        // Pin select and mode come before enable
        wr(ADDR_CTRL, 8'h20);
        for (int i = 0; i < 4; i++) wr(ADDR_HOLD, 8'($urandom));
        chk_st(8'h84, 8'h00);
        drain();
        for (int i = 0; i < 3; i++)
            chk(8'(atx_rx_model_i.starts[i + 1] - atx_rx_model_i.starts[i]),
                8'(10 * BIT), "frame spacing");
        atx_rx_model_i.starts.delete();
        chk_st(8'h84, 8'h84);
        $display("test burst done");

        wr(ADDR_STAT, 8'h80);
        chk_st(8'h04, 8'h04);
        wr(ADDR_STAT, 8'h00);
        chk_st(8'h84, 8'h00);
        wr(ADDR_STAT, 8'h04);
        chk_st(8'h04, 8'h00);
        $display("test flag clear done");

        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MODE, 8'h48);
        wr(ADDR_CTRL, 8'h20);
        wr(ADDR_HOLD, 8'($urandom));
        chk_st(8'h04, 8'h00);
        drain();
        chk_st(8'h84, 8'h84);
        chk(8'(atx_rx_model_i.frame_err), 8'h00, "framing");
        $display("test short char done");

        wr(ADDR_HOLD, 8'h00);
        repeat (3 * BIT) @(posedge clk_i);
        wr(ADDR_CTRL, 8'h00);
        // Registered line goes high one edge after the disable lands
        @(posedge clk_i);
        exp_q.delete();
        lows = 0;
        for (int n = 0; n < 12 * BIT; n++) begin
            @(posedge clk_i);
            if (line !== 1'b1) lows++;
        end
        chk(8'(lows), 8'h00, "line after abort");
        chk_st(8'h84, 8'h84);
        atx_rx_model_i.got.delete();
        $display("test abort done");
        finish_test();
    end

    initial begin
        #300000;
        err_total++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test();
    end
endmodule : async_serial_tx_enable_end_tb
`default_nettype wire
